//--- logic/ocd_ir_decoder.sv
`timescale 1ns/1ps
`include "ocd_params.svh"
module ocd_ir_decoder (
   input  wire ocd_pkg::ocd_opcode_t ir_value,
   input  wire logic                 dma_opcode_suppress_n,
   output wire ocd_pkg::ocd_opcode_t opcode,
   output wire ocd_pkg::ocd_instr_t  instr_lines
);
   function automatic ocd_pkg::ocd_instr_t onehot8(input ocd_pkg::ocd_opcode_t v);
      onehot8 = `OCD_INSTR_RESET << v;
   endfunction

   // Suppressed register reads as opcode zero, the logical-AND line
   assign opcode      = dma_opcode_suppress_n ? ir_value : `OCD_OP_AND;
   assign instr_lines = onehot8(opcode);
endmodule

//--- logic/ocd_opcode_decode.sv
`timescale 1ns/1ps
`include "ocd_params.svh"
module ocd_opcode_decode (
   input  wire  logic                 core_clk,
   input  wire  logic                 reset,
   input  wire  logic [3:0]           avs_address,
   input  wire  logic                 avs_read,
   input  wire  logic                 avs_write,
   input  wire  logic [31:0]          avs_writedata,
   input  wire  logic [3:0]           avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   input  wire  ocd_pkg::ocd_opcode_t memory_data_lines,
   input  wire  logic                 time_pulse_two,
   input  wire  logic                 time_pulse_four,
   input  wire  logic                 time_state_one,
   input  wire  logic                 time_state_two,
   input  wire  logic                 time_state_three,
   input  wire  logic                 time_state_four,
   input  wire  logic                 fetch_state,
   input  wire  logic                 execute_state,
   input  wire  logic                 dma_opcode_suppress_n,
   input  wire  logic                 irq_service_forced,
   input  wire  logic                 forced_exec_indirect_state_n,
   input  wire  logic                 instr_complete_n,
   input  wire  logic                 key_control_n,
   input  wire  logic                 brk_zero_req,
   input  wire  logic                 io_pc_add_req,
   output ocd_pkg::ocd_opcode_t       instruction_reg_n,
   output ocd_pkg::ocd_instr_t        basic_instr,
   output logic                       reg_in_sel0_n,
   output logic                       reg_in_sel1_n,
   output logic                       reg_in_sel2_n,
   output logic                       enter_execute
);
   ocd_pkg::ocd_opcode_t ir_q;
   ocd_pkg::ocd_opcode_t ir_d;
   ocd_pkg::ocd_opcode_t opcode_w;
   ocd_pkg::ocd_instr_t  instr_w;
   ocd_pkg::ocd_sel_t    sel_w;
   ocd_pkg::ocd_count_t  fcount_q;
   ocd_pkg::ocd_count_t  fcount_d;
   logic                 capen_q;
   logic                 wait_q;
   logic [31:0]          rdata_q;
   logic [31:0]          rdata_d;
   logic [31:0]          status_w;

   // ---------------- Instruction register ----------------
   wire dma_state  = ~dma_opcode_suppress_n;
   wire capture    = fetch_state & time_pulse_two & capen_q;
   wire force_call = time_pulse_four & irq_service_forced;

   // Force is applied even under DMA suppress, so the call waits in the register
   assign ir_d = force_call ? `OCD_OP_JMS :
                 capture    ? memory_data_lines :
                 ir_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ir_q <= `OCD_IR_RESET;
      end else begin
         ir_q <= ir_d;
      end
   end

   ocd_ir_decoder u_dec (
      .ir_value              (ir_q),
      .dma_opcode_suppress_n (dma_opcode_suppress_n),
      .opcode                (opcode_w),
      .instr_lines           (instr_w)
   );

   // ---------------- Register-in select ----------------
   ocd_sel_encoder u_sel (
      .time_state_one      (time_state_one),
      .time_state_two      (time_state_two),
      .time_state_three    (time_state_three),
      .time_state_four     (time_state_four),
      .fetch_state         (fetch_state),
      .execute_state       (execute_state),
      .dma_state           (dma_state),
      .key_control_n       (key_control_n),
      .instr_complete_n    (instr_complete_n),
      .forced_exec_indirect_state_n (forced_exec_indirect_state_n),
      .brk_zero_req        (brk_zero_req),
      .io_pc_add_req       (io_pc_add_req),
      .instr_lines         (instr_w),
      .sel_n               (sel_w)
   );

   // Outputs are registered: one cycle behind the time state, but glitch free
   always_ff @(posedge core_clk) begin
      if (reset) begin
         instruction_reg_n <= ~`OCD_IR_RESET;
         basic_instr       <= `OCD_INSTR_RESET;
         reg_in_sel0_n     <= 1'h1;
         reg_in_sel1_n     <= 1'h1;
         reg_in_sel2_n     <= 1'h1;
         enter_execute     <= 1'h0;
      end else begin
         instruction_reg_n <= ~opcode_w;
         basic_instr       <= instr_w;
         reg_in_sel0_n     <= sel_w[2];
         reg_in_sel1_n     <= sel_w[1];
         reg_in_sel2_n     <= sel_w[0];
         enter_execute     <= force_call;
      end
   end

   // ---------------- Avalon-MM slave ----------------
   wire req      = avs_read | avs_write;
   wire commit   = req & ~wait_q;
   wire hit_ctrl = avs_address == `OCD_ADDR_CTRL;
   wire hit_st   = avs_address == `OCD_ADDR_STATUS;
   wire hit_fc   = avs_address == `OCD_ADDR_FCOUNT;
   wire wr_ctrl  = commit & avs_write & hit_ctrl & avs_byteenable[0];
   wire wr_fc    = commit & avs_write & hit_fc;

   always_comb begin
      status_w = '0;
      status_w[`OCD_ST_IR_LSB +: 3]    = ir_q;
      status_w[`OCD_ST_INSTR_LSB +: 8] = basic_instr;
      status_w[`OCD_ST_SEL_LSB +: 3]   = {reg_in_sel0_n, reg_in_sel1_n, reg_in_sel2_n};
      status_w[`OCD_ST_DMA_BIT]        = dma_state;
      status_w[`OCD_ST_EXEC_BIT]       = enter_execute;
   end

   // Unmapped addresses read zero and ignore writes
   assign rdata_d = hit_ctrl ? {31'h0, capen_q} :
                    hit_st   ? status_w :
                    hit_fc   ? {16'h0, fcount_q} :
                    32'h0;

   // A forced call in the clearing cycle is still counted
   assign fcount_d = force_call ? (wr_fc ? `OCD_FCOUNT_ONE : ocd_pkg::ocd_count_t'(fcount_q + `OCD_FCOUNT_ONE)) :
                     wr_fc      ? '0 :
                     fcount_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wait_q   <= 1'h1;
         rdata_q  <= '0;
         capen_q  <= `OCD_CTRL_RESET;
         fcount_q <= '0;
      end else begin
         wait_q   <= ~(req & wait_q);
         rdata_q  <= rdata_d;
         fcount_q <= fcount_d;
         if (wr_ctrl) begin
            capen_q <= avs_writedata[`OCD_CTRL_CAPEN];
         end
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata    = rdata_q;

   // ---------------- Assertions ----------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   property p_capture;
      capture && !force_call |=> ir_q == $past(memory_data_lines);
   endproperty
   a_capture: assert property (p_capture) else $error("opcode not captured at fetch pulse");

   property p_hold;
      !(fetch_state && time_pulse_two) && !force_call |=> ir_q == $past(ir_q);
   endproperty
   a_hold: assert property (p_hold) else $error("opcode changed outside capture");

   property p_ir_lines;
      dma_opcode_suppress_n |=> instruction_reg_n == ~$past(ir_q);
   endproperty
   a_ir_lines: assert property (p_ir_lines) else $error("opcode lines not active low copy");

   property p_onehot;
      1'b1 |-> $onehot(basic_instr);
   endproperty
   a_onehot: assert property (p_onehot) else $error("decode not one-hot");

   property p_tad;
      dma_opcode_suppress_n && ir_q == `OCD_OP_TAD |=> basic_instr[`OCD_OP_TAD];
   endproperty
   a_tad: assert property (p_tad) else $error("add line not decoded");

   property p_suppress;
      !dma_opcode_suppress_n |=> basic_instr == `OCD_INSTR_RESET && instruction_reg_n == ~`OCD_OP_AND;
   endproperty
   a_suppress: assert property (p_suppress) else $error("suppress did not show opcode zero");

   property p_release;
      $rose(dma_opcode_suppress_n) |=> basic_instr == (`OCD_INSTR_RESET << $past(ir_q));
   endproperty
   a_release: assert property (p_release) else $error("decode not restored after release");

   sequence s_forced;
      time_pulse_four && irq_service_forced;
   endsequence

   property p_force;
      s_forced |=> ir_q == `OCD_OP_JMS && enter_execute;
   endproperty
   a_force: assert property (p_force) else $error("forced call not loaded");

   property p_dma_first;
      s_forced ##1 !dma_opcode_suppress_n |-> ir_q == `OCD_OP_JMS;
   endproperty
   a_dma_first: assert property (p_dma_first) else $error("call lost across data break");

   property p_no_mq;
      1'b1 |-> {reg_in_sel0_n, reg_in_sel1_n, reg_in_sel2_n} != `OCD_SEL_MQ;
   endproperty
   a_no_mq: assert property (p_no_mq) else $error("MQ select generated");

   property p_key_pc;
      time_state_four && !key_control_n |=> {reg_in_sel0_n, reg_in_sel1_n, reg_in_sel2_n} == `OCD_SEL_PC;
   endproperty
   a_key_pc: assert property (p_key_pc) else $error("manual TS4 not PC");

   property p_fetch_cpu_memory_address_reg;
      time_state_one && fetch_state && !io_pc_add_req
         |=> {reg_in_sel0_n, reg_in_sel1_n, reg_in_sel2_n} == `OCD_SEL_CPU_MEMORY_ADDRESS_REG;
   endproperty
   a_fetch_cpu_memory_address_reg: assert property (p_fetch_cpu_memory_address_reg) else $error("fetch TS1 not CPU_MEMORY_ADDRESS_REG");

   property p_zero_opr;
      time_state_three && dma_opcode_suppress_n && key_control_n && !io_pc_add_req
         && (ir_q == `OCD_OP_OPR || ir_q == `OCD_OP_IOT) |=> reg_in_sel0_n;
   endproperty
   a_zero_opr: assert property (p_zero_opr) else $error("operate TS3 not zero");

   property p_int_zero;
      time_state_four && key_control_n && !forced_exec_indirect_state_n && !time_state_one
         && !(ir_q == `OCD_OP_IOT && io_pc_add_req) |=> reg_in_sel0_n;
   endproperty
   a_int_zero: assert property (p_int_zero) else $error("forced TS4 selected PC");
endmodule

//--- logic/ocd_params.svh
`ifndef OCD_PARAMS_SVH
`define OCD_PARAMS_SVH

// Register byte addresses on the slave port
`define OCD_ADDR_CTRL      4'h0
`define OCD_ADDR_STATUS    4'h4
`define OCD_ADDR_FCOUNT    4'h8

// Control register
`define OCD_CTRL_CAPEN     0
`define OCD_CTRL_RESET     1'h1

// Status register field positions
`define OCD_ST_IR_LSB      0
`define OCD_ST_INSTR_LSB   8
`define OCD_ST_SEL_LSB     16
`define OCD_ST_DMA_BIT     20
`define OCD_ST_EXEC_BIT    21

// Opcode values
`define OCD_OP_AND         3'h0
`define OCD_OP_TAD         3'h1
`define OCD_OP_JMS         3'h4
`define OCD_OP_IOT         3'h6
`define OCD_OP_OPR         3'h7

// Register-in select codes, bit order {sel0_n, sel1_n, sel2_n}
`define OCD_SEL_PC         3'h0
`define OCD_SEL_MD         3'h1
`define OCD_SEL_MQ         3'h2
`define OCD_SEL_CPU_MEMORY_ADDRESS_REG       3'h3
`define OCD_SEL_ZERO       3'h7

// Reset values and forced-call count step
`define OCD_IR_RESET       3'h0
`define OCD_INSTR_RESET    8'h01
`define OCD_FCOUNT_ONE     16'h0001

`endif

//--- logic/ocd_pkg.sv
package ocd_pkg;
   typedef logic [2:0]  ocd_opcode_t;
   typedef logic [7:0]  ocd_instr_t;
   typedef logic [2:0]  ocd_sel_t;
   typedef logic [15:0] ocd_count_t;
endpackage

//--- logic/ocd_sel_encoder.sv
`timescale 1ns/1ps
`include "ocd_params.svh"
module ocd_sel_encoder (
   input  wire logic                time_state_one,
   input  wire logic                time_state_two,
   input  wire logic                time_state_three,
   input  wire logic                time_state_four,
   input  wire logic                fetch_state,
   input  wire logic                execute_state,
   input  wire logic                dma_state,
   input  wire logic                key_control_n,
   input  wire logic                instr_complete_n,
   input  wire logic                forced_exec_indirect_state_n,
   input  wire logic                brk_zero_req,
   input  wire logic                io_pc_add_req,
   input  wire ocd_pkg::ocd_instr_t instr_lines,
   output wire ocd_pkg::ocd_sel_t   sel_n
);
   wire is_jms = instr_lines[`OCD_OP_JMS];
   wire is_iot = instr_lines[`OCD_OP_IOT];
   wire is_opr = instr_lines[`OCD_OP_OPR];
   wire key_on = ~key_control_n;

   wire pc_manual = time_state_four & key_on;
   // Interrupt-forced call leaves PC off, so CPU_MEMORY_ADDRESS_REG is loaded with zero
   wire pc_auto   = time_state_four & ~instr_complete_n & ~dma_state & forced_exec_indirect_state_n;
   wire pc_jms    = time_state_two & execute_state & is_jms;
   wire pc_iot    = io_pc_add_req & is_iot;
   wire want_pc   = pc_manual | pc_auto | pc_jms | pc_iot;

   wire want_cpu_memory_address_reg = (time_state_one & (fetch_state | key_on))
                  | (time_state_three & execute_state & is_jms);

   // MQ code is never produced here; only the arithmetic option drives it
   assign sel_n = want_pc   ? `OCD_SEL_PC   :
                  want_cpu_memory_address_reg ? `OCD_SEL_CPU_MEMORY_ADDRESS_REG :
                  `OCD_SEL_ZERO;

   // Zero during TS3 of OPERATE_OP, of IO_TRANSFER_OP without io_pc_add_req, or a data break in TS2 is the default code
   wire unused_zero_terms = (time_state_three & (is_opr | is_iot)) | (time_state_two & dma_state & brk_zero_req);
endmodule

//--- test/ocd_far_model.sv
`timescale 1ns/1ps
module ocd_far_model (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic                 fetch_state,
   input  wire logic                 time_pulse_four,
   input  wire logic                 iot_line,
   input  wire ocd_pkg::ocd_opcode_t word,
   input  wire logic                 brk_req,
   input  wire logic                 pc_add_en,
   output ocd_pkg::ocd_opcode_t      memory_data_lines,
   output logic                      dma_opcode_suppress_n,
   output logic                      brk_zero_req,
   output logic                      io_pc_add_req
);
   always_ff @(posedge core_clk) begin
      if (reset) begin
         memory_data_lines     <= 3'h0;
         dma_opcode_suppress_n <= 1'b1;
      end else begin
         // Released lines toggle so stale data is never captured by luck
         memory_data_lines <= fetch_state ? word : ~memory_data_lines;
         // Break starts and ends on a time pulse four only
         if (time_pulse_four) dma_opcode_suppress_n <= dma_opcode_suppress_n ? ~brk_req : 1'b1;
      end
   end
   assign brk_zero_req  = ~dma_opcode_suppress_n;
   assign io_pc_add_req = pc_add_en & iot_line;
endmodule

//--- test/ocd_opcode_decode_tb.sv
`timescale 1ns/1ps
`include "ocd_params.svh"
module ocd_opcode_decode_tb;
   logic                 core_clk, reset, avs_read, avs_write, time_pulse_two, time_pulse_four;
   logic                 time_state_one, time_state_two, time_state_three, time_state_four;
   logic                 fetch_state, execute_state, irq_service_forced, forced_exec_indirect_state_n;
   logic                 instr_complete_n, key_control_n, brk_req, pc_add_en, cap_en_e, supp_e;
   logic                 dma_opcode_suppress_n, brk_zero_req, io_pc_add_req, avs_waitrequest;
   logic                 reg_in_sel0_n, reg_in_sel1_n, reg_in_sel2_n, enter_execute;
   logic [3:0]           avs_address;
   logic [31:0]          avs_writedata, avs_readdata, ee_cnt;
   logic [15:0]          lfsr;
   logic [1:0]           obs_kind;
   ocd_pkg::ocd_opcode_t word, ir_e, memory_data_lines, instruction_reg_n;
   ocd_pkg::ocd_instr_t  basic_instr;
   logic [31:0]          q[$];
   string                nq[$];
   int                   miscompares, checked, cycles;

   ocd_opcode_decode i_ocd_opcode_decode (.core_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .memory_data_lines, .time_pulse_two, .time_pulse_four,
      .time_state_one, .time_state_two, .time_state_three, .time_state_four, .fetch_state, .execute_state,
      .dma_opcode_suppress_n, .irq_service_forced, .forced_exec_indirect_state_n, .instr_complete_n, .key_control_n,
      .brk_zero_req, .io_pc_add_req, .instruction_reg_n, .basic_instr, .reg_in_sel0_n, .reg_in_sel1_n,
      .reg_in_sel2_n, .enter_execute);
   ocd_far_model i_ocd_far_model (.core_clk, .reset, .fetch_state, .time_pulse_four, .iot_line(basic_instr[6]),
      .word, .brk_req, .pc_add_en, .memory_data_lines, .dma_opcode_suppress_n, .brk_zero_req, .io_pc_add_req);

   always #50 core_clk = ~core_clk;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [31:0] exp_obs();
      logic [7:0] ln;
      logic       pc, cp;
      ln = supp_e ? 8'h01 : 8'h01 << ir_e;
      pc = (time_state_four & ~key_control_n) | (time_state_four & ~instr_complete_n & ~supp_e & forced_exec_indirect_state_n)
           | (time_state_two & execute_state & ln[4]) | (pc_add_en & ln[6]);
      cp = (time_state_one & (fetch_state | ~key_control_n)) | (time_state_three & execute_state & ln[4]);
      return {18'h0, supp_e ? 3'h7 : ~ir_e, ln, pc ? `OCD_SEL_PC : (cp ? `OCD_SEL_CPU_MEMORY_ADDRESS_REG : `OCD_SEL_ZERO)};
   endfunction

   task automatic note(input logic [31:0] e, input string n);
      q.push_back(e);
      nq.push_back(n);
   endtask

   task automatic cmp(input logic [31:0] got);
      logic [31:0] e;
      string       n;
      e = (q.size() > 0) ? q.pop_front() : 32'hffff_ffff;
      n = (nq.size() > 0) ? nq.pop_front() : "none";
      checked++;
      if (got !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, got);
      end
   endtask

   task automatic av_bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      if (n >= 64) begin
         miscompares++;
         $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
      end
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      note(e, "readdata");
      av_bus(1'b0, a, 32'h0);
   endtask

   task automatic obs(input logic [1:0] kind, input logic [31:0] e);
      repeat (4) @(posedge core_clk);
      note(e, kind == 2'h1 ? "decode_select" : "forced_calls");
      obs_kind <= kind;
      @(posedge core_clk);
      obs_kind <= 2'h0;
   endtask

   task automatic capture(input ocd_pkg::ocd_opcode_t op);
      @(posedge core_clk);
      fetch_state <= 1'b1;
      word        <= op;
      repeat (2) @(posedge core_clk);
      time_pulse_two <= 1'b1;
      @(posedge core_clk);
      time_pulse_two <= 1'b0;
      fetch_state    <= 1'b0;
      if (cap_en_e) ir_e = op;
   endtask

   task automatic p4(input logic irq_v, input logic brk);
      @(posedge core_clk);
      time_pulse_four    <= 1'b1;
      irq_service_forced <= irq_v;
      brk_req            <= brk;
      @(posedge core_clk);
      time_pulse_four    <= 1'b0;
      irq_service_forced <= 1'b0;
      if (irq_v) ir_e = `OCD_OP_JMS;
      supp_e = supp_e ? 1'b0 : brk;
   endtask

   task end_sim();
      $display("Checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Results are judged against the oldest note, in the order they were driven
   always @(posedge core_clk) begin
      if (enter_execute === 1'b1 && !reset) ee_cnt <= ee_cnt + 32'h1;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(avs_readdata);
      if (obs_kind == 2'h1) cmp({18'h0, instruction_reg_n, basic_instr, reg_in_sel0_n, reg_in_sel1_n, reg_in_sel2_n});
      if (obs_kind == 2'h2) cmp(ee_cnt);
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_sim();
      end
   end

   initial begin
      core_clk = 1'b0;
      {avs_read, avs_write, time_pulse_two, time_pulse_four, fetch_state, execute_state} = '0;
      {time_state_one, time_state_two, time_state_three, time_state_four, irq_service_forced} = '0;
      {brk_req, pc_add_en, supp_e, obs_kind} = '0;
      {instr_complete_n, key_control_n, forced_exec_indirect_state_n, cap_en_e, reset} = '1;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      word = 3'h0;
      ir_e = `OCD_OP_AND;
      ee_cnt = 32'h0;
      lfsr = 16'h0043;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      obs(2'h1, exp_obs());
      rd(`OCD_ADDR_STATUS, 32'h0007_0100);
      rd(`OCD_ADDR_CTRL, 32'h1);
      rd(4'hc, 32'h0);
      $display("Test reset finished");
      for (int i = 0; i < 8; i++) begin
         capture(i[2:0]);
         obs(2'h1, exp_obs());
      end
      // Pulse two outside fetch must not load the register
      @(posedge core_clk);
      time_pulse_two <= 1'b1;
      @(posedge core_clk);
      time_pulse_two <= 1'b0;
      obs(2'h1, exp_obs());
      av_bus(1'b1, `OCD_ADDR_CTRL, 32'h0);
      cap_en_e = 1'b0;
      capture(3'h2);
      obs(2'h1, exp_obs());
      rd(`OCD_ADDR_CTRL, 32'h0);
      av_bus(1'b1, `OCD_ADDR_CTRL, 32'h1);
      cap_en_e = 1'b1;
      $display("Test capture finished");
      capture(`OCD_OP_TAD);
      p4(1'b0, 1'b1);
      obs(2'h1, exp_obs());
      p4(1'b0, 1'b0);
      obs(2'h1, exp_obs());
      p4(1'b1, 1'b1);
      obs(2'h1, exp_obs());
      p4(1'b0, 1'b0);
      obs(2'h1, exp_obs());
      capture(`OCD_OP_OPR);
      p4(1'b1, 1'b0);
      obs(2'h1, exp_obs());
      obs(2'h2, 32'h2);
      rd(`OCD_ADDR_FCOUNT, 32'h2);
      av_bus(1'b1, `OCD_ADDR_FCOUNT, 32'h0);
      rd(`OCD_ADDR_FCOUNT, 32'h0);
      $display("Test forced call finished");
      for (int i = 0; i < 48; i++) begin
         lfsr = lfsr_next(lfsr);
         capture(lfsr[2:0]);
         @(posedge core_clk);
         {time_state_one, time_state_two, time_state_three, time_state_four} <= 4'h1 << lfsr[4:3];
         fetch_state         <= lfsr[5];
         execute_state       <= lfsr[6];
         key_control_n       <= lfsr[7] | lfsr[8];
         instr_complete_n    <= lfsr[9];
         forced_exec_indirect_state_n <= lfsr[10];
         pc_add_en           <= lfsr[11];
         // Let the new inputs settle before the expectation reads them
         @(posedge core_clk);
         obs(2'h1, exp_obs());
      end
      $display("Test select finished");
      end_sim();
   end
endmodule
